// ==== bench/sprst_host.sv ====
// Model of the user push-button and the host's control pins.
// Assumes requests are set at the falling edge; the pins change after the next rising edge.
`timescale 1ns/10ps
module sprst_host
(
	input wire logic clk,
	input wire logic press_go,
	input wire logic [15:0] press_len,
	input wire logic cd_req,
	input wire logic ls_req,
	output logic pushbutton_in,
	output logic chip_disable_n,
	output logic load_switch_control
);
	logic [15:0] left = 16'h0000;
	initial
	begin
		pushbutton_in = 1'b1;
		chip_disable_n = 1'b0;
		load_switch_control = 1'b0;
	end
	always @(posedge clk)
	begin
		chip_disable_n <= cd_req;
		load_switch_control <= ls_req;
		if (press_go)
			left <= press_len;
		else if (left != 16'h0000)
			left <= left - 16'h0001;
		pushbutton_in <= !press_go && left < 16'h0002;
	end
endmodule

// ==== bench/sprst_top_asserts.sv ====
// Concurrent checks on the status line, power-good pin, push-button reset and current outputs.
// Assumes the bench sets a fault pulse of 8 cycles; bound to every sprst_top instance.
`timescale 1ns/10ps
module sprst_top_asserts
#(
	parameter int MS_TICK_CYC = 4
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pushbutton_in,
	input wire logic load_switch_control,
	input wire logic vin_in_range,
	input wire logic charge_mode,
	input wire logic status_out_enable,
	input wire logic pushbutton_shifted_out_en,
	input wire logic term_override_en,
	input wire sprst_pkg::sprst_term_t term_override_value,
	input wire logic status_line_oe,
	input wire logic power_good_oe,
	input wire logic reset_n_oe,
	input wire logic ship_mode,
	input wire logic ship_mode_exit,
	input wire sprst_pkg::sprst_ts_t thermistor_fault,
	input wire sprst_pkg::sprst_term_t termination_current,
	input wire sprst_pkg::sprst_term_t precharge_current,
	input wire logic load_switch_enable
);
	import sprst_pkg::*;
	int rcnt;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// Counting the low time here keeps the long release delay out of any repetition.
	always_ff @(posedge clk)
	begin
		rcnt <= (sys_rst || !reset_n_oe) ? 0 : rcnt + 1;
	end
	property p_pg;
		(!pushbutton_shifted_out_en && $stable(vin_in_range))[*6] |-> power_good_oe == vin_in_range;
	endproperty
	property p_shift;
		(pushbutton_shifted_out_en && $stable(pushbutton_in))[*6] |-> power_good_oe == !pushbutton_in;
	endproperty
	property p_ls;
		$stable(load_switch_control)[*6] |-> load_switch_enable == load_switch_control;
	endproperty
	property p_pre;
		precharge_current == termination_current;
	endproperty
	property p_ovr;
		term_override_en |=> termination_current == $past(term_override_value);
	endproperty
	property p_therm;
		!charge_mode |=> thermistor_fault == 4'h0;
	endproperty
	property p_pulse;
		$rose(status_line_oe) && !status_out_enable |-> status_line_oe[*8] ##1 !status_line_oe;
	endproperty
	property p_rel;
		$fell(reset_n_oe) |-> rcnt == 400 * MS_TICK_CYC;
	endproperty
	property p_hold;
		$rose(reset_n_oe) |-> !$past(pushbutton_in, 4);
	endproperty
	property p_ship;
		ship_mode_exit |-> $past(ship_mode) && !ship_mode;
	endproperty
	a_pg: assert property (p_pg) else $error("power good level wrong");
	a_shift: assert property (p_shift) else $error("shifted power good wrong");
	a_ls: assert property (p_ls) else $error("load switch wrong");
	a_pre: assert property (p_pre) else $error("precharge differs");
	a_ovr: assert property (p_ovr) else $error("override ignored");
	a_therm: assert property (p_therm) else $error("thermistor fault outside charge");
	a_pulse: assert property (p_pulse) else $error("fault pulse length wrong");
	a_rel: assert property (p_rel) else $error("reset release delay wrong");
	a_hold: assert property (p_hold) else $error("reset without press");
	a_ship: assert property (p_ship) else $error("ship exit wrong");
	c_rst: cover property ($rose(reset_n_oe));
	c_ship: cover property (ship_mode_exit);
	c_pulse: cover property ($rose(status_line_oe) && !status_out_enable);
endmodule

bind sprst_top sprst_top_asserts #(.MS_TICK_CYC(MS_TICK_CYC)) i_sprst_top_asserts (.*);

// ==== bench/test_status_and_pushbutton_reset_logic.sv ====
// Self-checking bench for sprst_top with shortened millisecond tick and fault pulse.
// Assumes the host model drives the push-button and control pins.
`timescale 1ns/10ps
module test_status_and_pushbutton_reset_logic;
	import sprst_pkg::*;
	localparam int TK = 4;
	logic clk = 1'b0, sys_rst = 1'b1, press_go = 1'b0, cd_req = 1'b0, ls_req = 1'b0;
	logic [15:0] press_len = 16'h0000;
	logic pushbutton_in, chip_disable_n, load_switch_control;
	logic vin_in_range = 1'b0, charging_active = 1'b0, charge_done = 1'b0, charger_hiz = 1'b0, fault_event = 1'b0;
	logic charge_mode = 1'b0, ship_mode_enter = 1'b0, status_out_enable = 1'b0, pushbutton_shifted_out_en = 1'b0;
	logic [1:0] pushbutton_hold_select = 2'h0;
	logic wake_first_select = 1'b0, wake_second_select = 1'b0, term_override_en = 1'b0;
	sprst_ts_t thermistor_sense = 4'h0, thermistor_fault;
	sprst_term_t termination_current_prog = 5'h00, term_override_value = 5'h00, termination_current, precharge_current;
	logic status_line_out, status_line_oe, power_good_out, power_good_oe, reset_n_out, reset_n_oe, wake_first_event;
	logic wake_second_event, ship_mode, ship_mode_exit, charge_allowed, active_battery_mode, load_switch_enable;
	logic [31:0] seed = 32'hCBBBBD5D;
	logic [5:0] st_case [5] = '{6'b111000, 6'b011100, 6'b011010, 6'b011001, 6'b001000};
	int fails = 0, tests_run = 0, cyc = 0, n_st = 0, n1 = 0, n2 = 0, nx = 0, nr = 0, base = 0;
	sprst_top #(.MS_TICK_CYC(TK), .FAULT_PULSE_CYC(8)) i_sprst_top (.*);
	sprst_host i_sprst_host (.*);
	always #2 clk = ~clk;
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		n_st <= n_st + (status_line_oe === 1'b1);
		n1 <= n1 + (wake_first_event === 1'b1);
		n2 <= n2 + (wake_second_event === 1'b1);
		nx <= nx + (ship_mode_exit === 1'b1);
		nr <= nr + (reset_n_oe === 1'b1);
		if (cyc == 70000)
		begin
			fails++;
			summarize();
		end
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	function automatic int w1_cyc(input logic s);
		return (s ? 600 : 80) * TK;
	endfunction
	function automatic int w2_cyc(input logic s);
		return (s ? 1500 : 1000) * TK;
	endfunction
	function automatic sprst_term_t exp_cur(input logic en, input sprst_term_t v, input sprst_term_t p);
		return en ? v : p;
	endfunction
	task chk(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1)
		begin
			fails++;
			$display("MISMATCH %0t %s", $time, m);
		end
	endtask
	task step(input int n);
		repeat (n) @(negedge clk);
	endtask
	// With input power absent the pin shows only the mirrored button, which makes the check exact.
	task press(input int len);
		seed = xs(seed);
		pushbutton_shifted_out_en = seed[0];
		press_go = 1'b1;
		press_len = 16'(len);
		step(1);
		press_go = 1'b0;
		step(len / 2);
		chk(power_good_oe === pushbutton_shifted_out_en, "power good during press");
		step(len / 2 + 12);
	endtask
	task summarize();
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		step(2);
		sys_rst = 1'b0;
		step(4);
		for (int i = 0; i < 24; i++)
		begin
			seed = xs(seed);
			{term_override_en, term_override_value, termination_current_prog} = seed[10:0];
			{ls_req, vin_in_range, thermistor_sense, charge_mode} = seed[17:11];
			step(12);
			chk(termination_current === exp_cur(term_override_en, term_override_value, termination_current_prog)
				&& precharge_current === termination_current, "currents");
			chk(load_switch_enable === ls_req && power_good_oe === vin_in_range, "levels");
			chk(thermistor_fault === (charge_mode ? thermistor_sense : 4'h0), "thermistor");
		end
		charge_mode = 1'b0;
		vin_in_range = 1'b0;
		step(20);
		n_st = 0;
		fault_event = 1'b1;
		step(1);
		fault_event = 1'b0;
		step(2);
		fault_event = 1'b1;
		step(1);
		fault_event = 1'b0;
		step(20);
		chk(n_st == 8, "fault pulse length");
		chk(status_line_out === 1'b0 && power_good_out === 1'b0 && reset_n_out === 1'b0, "pin data");
		for (int k = 0; k < 5; k++)
		begin
			{status_out_enable, charging_active, charge_done, charger_hiz, cd_req} = st_case[k][4:0];
			step(8);
			chk(status_line_oe === st_case[k][5], "status line");
			chk(charge_allowed === !cd_req && active_battery_mode === (cd_req && !vin_in_range), "chip disable");
		end
		cd_req = 1'b0;
		for (int s = 0; s < 2; s++)
		begin
			wake_first_select = s[0];
			base = n1;
			press(w1_cyc(s[0]) - 20);
			chk(n1 == base, "early release");
			press(w1_cyc(s[0]) + 20);
			chk(n1 == base + 1 && n2 == 0, "first wake");
		end
		wake_second_select = seed[1];
		press(w2_cyc(seed[1]) + 20);
		chk(n2 == 1, "second wake");
		ship_mode_enter = 1'b1;
		step(1);
		ship_mode_enter = 1'b0;
		step(2);
		chk(ship_mode === 1'b1, "ship entered");
		base = nx;
		press(100);
		chk(ship_mode === 1'b0 && nx == base + 1, "ship exit");
		press(4000 * TK - 50);
		chk(nr == 0 && reset_n_oe === 1'b0, "reset too early");
		press(4000 * TK + 50);
		step(1700);
		chk(nr == 400 * TK && reset_n_oe === 1'b0, "reset length");
		// A longer selected hold must swallow a press that the shortest hold would have turned into a reset.
		seed = xs(seed);
		pushbutton_hold_select = (seed[3:2] == 2'h0) ? 2'h1 : seed[3:2];
		press(4000 * TK + 50);
		chk(nr == 400 * TK && reset_n_oe === 1'b0, "longer hold selected");
		summarize();
	end
endmodule

// ==== core/sprst_consts.svh ====
// Constants of the status and push-button supervision block.
// Assumes a 250 MHz core clock; all times are derived from it in the top module.
`ifndef SPRST_CONSTS_SVH
`define SPRST_CONSTS_SVH

`define SPRST_CLK_MHZ 250
`define SPRST_US_PER_MS 1000
`define SPRST_FAULT_PULSE_US 128
`define SPRST_RELEASE_MS 16'h0190

`define SPRST_HOLD_MS_0 16'h0FA0
`define SPRST_HOLD_MS_1 16'h1F40
`define SPRST_HOLD_MS_2 16'h2EE0
`define SPRST_HOLD_MS_3 16'h3E80
`define SPRST_WAKE1_MS_0 16'h0050
`define SPRST_WAKE1_MS_1 16'h0258
`define SPRST_WAKE2_MS_0 16'h03E8
`define SPRST_WAKE2_MS_1 16'h05DC

`define SPRST_TERM_W 5
`define SPRST_TS_W 4
`define SPRST_MS_W 16
`define SPRST_SYNC_W 8

`define SPRST_PIN_PB 0
`define SPRST_PIN_CD 1
`define SPRST_PIN_LS 2
`define SPRST_PIN_VIN 3
`define SPRST_PIN_TS 4
`define SPRST_SYNC_RST 8'h01

`endif

// ==== core/sprst_pkg.sv ====
// Types shared by the status and push-button supervision block.
// Assumes the constants header is on the include path.
`include "sprst_consts.svh"

package sprst_pkg;

	typedef enum logic [2:0]
	{
		SPRST_IDLE = 3'h1,
		SPRST_TIMING = 3'h2,
		SPRST_WAIT_UP = 3'h4
	} sprst_press_t;

	typedef logic [`SPRST_MS_W-1:0] sprst_ms_t;
	typedef logic [`SPRST_TERM_W-1:0] sprst_term_t;
	typedef logic [`SPRST_TS_W-1:0] sprst_ts_t;

endpackage

// ==== core/sprst_top.sv ====
// Status line, power-good pin, push-button timing and reset output logic.
// Assumes analog comparators deliver raw levels on the pin inputs and the charger logic shares clk.
`timescale 1ns/10ps
`include "sprst_consts.svh"

module sprst_top
#(
	parameter int MS_TICK_CYC = `SPRST_CLK_MHZ * `SPRST_US_PER_MS,
	parameter int FAULT_PULSE_CYC = `SPRST_FAULT_PULSE_US * `SPRST_CLK_MHZ
)
(
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic pushbutton_in,
	input wire logic chip_disable_n,
	input wire logic load_switch_control,
	input wire logic vin_in_range,
	input wire sprst_pkg::sprst_ts_t thermistor_sense,
	input wire logic charging_active,
	input wire logic charge_done,
	input wire logic charger_hiz,
	input wire logic fault_event,
	input wire logic charge_mode,
	input wire logic ship_mode_enter,
	input wire logic status_out_enable,
	input wire logic pushbutton_shifted_out_en,
	input wire logic [1:0] pushbutton_hold_select,
	input wire logic wake_first_select,
	input wire logic wake_second_select,
	input wire sprst_pkg::sprst_term_t termination_current_prog,
	input wire logic term_override_en,
	input wire sprst_pkg::sprst_term_t term_override_value,
	output logic status_line_out,
	output logic status_line_oe,
	output logic power_good_out,
	output logic power_good_oe,
	output logic reset_n_out,
	output logic reset_n_oe,
	output logic wake_first_event,
	output logic wake_second_event,
	output logic ship_mode,
	output logic ship_mode_exit,
	output sprst_pkg::sprst_ts_t thermistor_fault,
	output sprst_pkg::sprst_term_t termination_current,
	output sprst_pkg::sprst_term_t precharge_current,
	output logic charge_allowed,
	output logic active_battery_mode,
	output logic load_switch_enable
);
	import sprst_pkg::*;

	localparam logic [23:0] TICK_LAST = 24'(MS_TICK_CYC - 1);
	localparam logic [15:0] PULSE_LAST = 16'(FAULT_PULSE_CYC - 1);

	logic [`SPRST_SYNC_W-1:0] pin_raw;
	logic [`SPRST_SYNC_W-1:0] sync_a;
	logic [`SPRST_SYNC_W-1:0] sync_b;
	logic [`SPRST_SYNC_W-1:0] sync_c;
	logic [`SPRST_SYNC_W-1:0] pin_level;
	logic [`SPRST_SYNC_W-1:0] pin_agree;
	logic pb_low;
	logic pb_low_q;
	logic press_start;
	sprst_press_t press_state;
	logic [23:0] press_tick;
	sprst_ms_t press_ms;
	sprst_ms_t next_press_ms;
	sprst_ms_t hold_ms;
	sprst_ms_t wake1_ms;
	sprst_ms_t wake2_ms;
	logic press_ms_tick;
	logic hold_hit;
	logic [23:0] rel_tick;
	sprst_ms_t rel_ms;
	sprst_ms_t next_rel_ms;
	logic [15:0] pulse_cnt;
	logic pulse_active;
	logic pulse_trigger;
	logic charge_ind;
	sprst_ts_t next_ts_fault;
	logic od_low;

	// Every open-drain pin only ever pulls low; the enables carry the information.
	always_ff @(posedge clk)
		od_low <= 1'b0;

	assign status_line_out = od_low;
	assign power_good_out = od_low;
	assign reset_n_out = od_low;

	assign pin_raw = {thermistor_sense, vin_in_range, load_switch_control, chip_disable_n, pushbutton_in};
	assign pin_agree = ~(sync_b ^ sync_c);

	// Three stages; a level is accepted only once the last two stages agree, which also rejects one-cycle glitches.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			sync_a <= `SPRST_SYNC_RST;
			sync_b <= `SPRST_SYNC_RST;
			sync_c <= `SPRST_SYNC_RST;
			pin_level <= `SPRST_SYNC_RST;
		end
		else
		begin
			sync_a <= pin_raw;
			sync_b <= sync_a;
			sync_c <= sync_b;
			pin_level <= (pin_level & ~pin_agree) | (sync_c & pin_agree);
		end
	end

	assign pb_low = ~pin_level[`SPRST_PIN_PB];
	assign press_start = pb_low & ~pb_low_q;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			pb_low_q <= 1'b0;
		else
			pb_low_q <= pb_low;
	end

	always_comb
		unique case (pushbutton_hold_select)
			2'h0: hold_ms = `SPRST_HOLD_MS_0;
			2'h1: hold_ms = `SPRST_HOLD_MS_1;
			2'h2: hold_ms = `SPRST_HOLD_MS_2;
			2'h3: hold_ms = `SPRST_HOLD_MS_3;
		endcase

	assign wake1_ms = wake_first_select ? `SPRST_WAKE1_MS_1 : `SPRST_WAKE1_MS_0;
	assign wake2_ms = wake_second_select ? `SPRST_WAKE2_MS_1 : `SPRST_WAKE2_MS_0;

	assign press_ms_tick = (press_state == SPRST_TIMING) && (press_tick == TICK_LAST);
	assign next_press_ms = press_ms + 16'h0001;
	assign hold_hit = press_ms_tick && (next_press_ms == hold_ms);

	// The selects are read live, so changing them mid-press moves the thresholds of that press.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			press_state <= SPRST_IDLE;
		else
			unique case (press_state)
				SPRST_IDLE:
					if (press_start)
						press_state <= SPRST_TIMING;
				SPRST_TIMING:
					if (!pb_low)
						press_state <= SPRST_IDLE;
					else if (hold_hit)
						press_state <= SPRST_WAIT_UP;
				SPRST_WAIT_UP:
					if (!pb_low)
						press_state <= SPRST_IDLE;
				default:
					press_state <= SPRST_IDLE;
			endcase
	end

	// The millisecond prescaler restarts with the press so that hold times are exact to one cycle.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			press_tick <= 24'h000000;
			press_ms <= 16'h0000;
		end
		else if (press_start)
		begin
			press_tick <= 24'h000000;
			press_ms <= 16'h0000;
		end
		else if (press_state == SPRST_TIMING)
		begin
			if (press_tick == TICK_LAST)
			begin
				press_tick <= 24'h000000;
				press_ms <= next_press_ms;
			end
			else
				press_tick <= press_tick + 24'h000001;
		end
	end

	// Wake events fire only while timing, so a release before the first duration gives none.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			wake_first_event <= 1'b0;
			wake_second_event <= 1'b0;
		end
		else
		begin
			wake_first_event <= press_ms_tick && (next_press_ms == wake1_ms);
			wake_second_event <= press_ms_tick && (next_press_ms == wake2_ms);
		end
	end

	assign next_rel_ms = rel_ms + 16'h0001;

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			reset_n_oe <= 1'b0;
			rel_tick <= 24'h000000;
			rel_ms <= 16'h0000;
		end
		else if (hold_hit)
		begin
			reset_n_oe <= 1'b1;
			rel_tick <= 24'h000000;
			rel_ms <= 16'h0000;
		end
		else if (reset_n_oe)
		begin
			if (rel_tick == TICK_LAST)
			begin
				rel_tick <= 24'h000000;
				rel_ms <= next_rel_ms;
				if (next_rel_ms == `SPRST_RELEASE_MS)
					reset_n_oe <= 1'b0;
			end
			else
				rel_tick <= rel_tick + 24'h000001;
		end
	end

	always_comb
		next_ts_fault = charge_mode ? pin_level[`SPRST_PIN_TS +: `SPRST_TS_W] : 4'h0;

	always_ff @(posedge clk)
		if (sys_rst)
			thermistor_fault <= 4'h0;
		else
			thermistor_fault <= next_ts_fault;

	assign pulse_trigger = fault_event | (|(next_ts_fault & ~thermistor_fault)) | wake_first_event | wake_second_event;

	// A trigger during a running pulse is absorbed; the host reads the cause over the status path anyway.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			pulse_active <= 1'b0;
			pulse_cnt <= 16'h0000;
		end
		else if (pulse_active)
		begin
			if (pulse_cnt == PULSE_LAST)
				pulse_active <= 1'b0;
			else
				pulse_cnt <= pulse_cnt + 16'h0001;
		end
		else if (pulse_trigger)
		begin
			pulse_active <= 1'b1;
			pulse_cnt <= 16'h0000;
		end
	end

	always_comb
		charge_ind = status_out_enable & charging_active & ~charge_done & ~charger_hiz & ~pin_level[`SPRST_PIN_CD];

	// The pulse inverts the line so that it stays visible even while charge indication holds it low.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			status_line_oe <= 1'b0;
		else
			status_line_oe <= charge_ind ^ pulse_active;
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			power_good_oe <= 1'b0;
		else if (pushbutton_shifted_out_en)
			power_good_oe <= pb_low;
		else
			power_good_oe <= pin_level[`SPRST_PIN_VIN];
	end

	// A press starting in the same cycle as an entry request wins; a button that is already held does not block entry.
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			ship_mode <= 1'b0;
			ship_mode_exit <= 1'b0;
		end
		else
		begin
			ship_mode_exit <= press_start & ship_mode;
			if (press_start)
				ship_mode <= 1'b0;
			else if (ship_mode_enter)
				ship_mode <= 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			termination_current <= 5'h00;
			precharge_current <= 5'h00;
		end
		else
		begin
			termination_current <= term_override_en ? term_override_value : termination_current_prog;
			precharge_current <= term_override_en ? term_override_value : termination_current_prog;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			charge_allowed <= 1'b0;
			active_battery_mode <= 1'b0;
			load_switch_enable <= 1'b0;
		end
		else
		begin
			charge_allowed <= ~pin_level[`SPRST_PIN_CD];
			active_battery_mode <= pin_level[`SPRST_PIN_CD] & ~pin_level[`SPRST_PIN_VIN];
			load_switch_enable <= pin_level[`SPRST_PIN_LS];
		end
	end

endmodule
